// ==== include/dtp_pkg.sv ====
/*
 Shared constants and carrier types for the paired 8-bit interval timer block.
 Assumes the prescaler taps and all control fields are produced on ref_clk.
*/
`default_nettype none
package dtp_pkg;
   localparam int CNT_W = 8;

   // Timer mode field encodings
   localparam logic [1:0] MODE_DUAL = 2'b00;
   localparam logic [1:0] MODE_16BIT = 2'b01;
   localparam logic [1:0] MODE_PPG = 2'b10;
   localparam logic [1:0] MODE_PWM = 2'b11;

   // Lower timer input clock select
   localparam logic [1:0] LCLK_EXT = 2'b00;
   localparam logic [1:0] LCLK_T1 = 2'b01;
   localparam logic [1:0] LCLK_T4 = 2'b10;
   localparam logic [1:0] LCLK_T16 = 2'b11;

   // Upper timer input clock select
   localparam logic [1:0] UCLK_MATCH = 2'b00;
   localparam logic [1:0] UCLK_T1 = 2'b01;
   localparam logic [1:0] UCLK_T16 = 2'b10;
   localparam logic [1:0] UCLK_T256 = 2'b11;

   // PWM cycle field and the matching 2^n overflow counts
   localparam logic [1:0] PWM_CYC_64 = 2'b01;
   localparam logic [1:0] PWM_CYC_128 = 2'b10;
   localparam logic [1:0] PWM_CYC_256 = 2'b11;
   localparam logic [CNT_W:0] PWM_LIM_64 = 9'h040;
   localparam logic [CNT_W:0] PWM_LIM_128 = 9'h080;
   localparam logic [CNT_W:0] PWM_LIM_256 = 9'h100;

   // Output flip-flop software commands
   localparam logic [1:0] FF_CMD_INVERT = 2'b00;
   localparam logic [1:0] FF_CMD_CLEAR = 2'b01;
   localparam logic [1:0] FF_CMD_SET = 2'b10;
   localparam logic [1:0] FF_CMD_HOLD = 2'b11;

   // Reset values
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CMP_RESET = 8'h00;
   localparam logic FF_RESET = 1'b0;
   localparam logic CMP_EN_RESET = 1'b1;

   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] pwm_cycle;
      logic [1:0] upper_clk_sel;
      logic [1:0] lower_clk_sel;
      logic dbuf_en;
      logic invert_en;
      logic out_select;
   } dtp_cfg_t;

   typedef struct packed {
      logic t1;
      logic t4;
      logic t16;
      logic t256;
   } dtp_taps_t;
endpackage
`default_nettype wire

// ==== logic/dtp_counter.sv ====
/*
 Up counter with stop-and-clear, used for both halves of the timer pair.
 Assumes tick and clear are single-cycle strobes on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_counter #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic run,
   input wire logic tick,
   input wire logic clear,
   output logic [WIDTH-1:0] count,
   output logic [WIDTH:0] count_plus
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   assign count_plus = {1'b0, count_reg} + {{WIDTH{1'b0}}, 1'b1};
   assign count = count_reg;

   // Clear beats a tick in the same cycle
   always_comb
   begin
      count_next = count_reg;
      if (!run || clear)
      begin
         count_next = '0;
      end
      else if (tick)
      begin
         count_next = count_plus[WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end
endmodule // dtp_counter
`default_nettype wire

// ==== logic/dtp_timer_pair.sv ====
/*
 Pair of 8-bit interval timers sharing one output flip-flop: dual 8-bit,
 cascaded 16-bit, 8-bit PPG and 8-bit PWM modes.
 Assumes taps are one-cycle enables from a prescaler on ref_clk; the
 external lower clock pin is asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_timer_pair (
   input wire logic ref_clk,
   input wire logic reset,
   input wire dtp_pkg::dtp_cfg_t cfg,
   input wire dtp_pkg::dtp_taps_t taps,
   input wire logic lower_ext_clk_pin,
   input wire logic lower_run_bit,
   input wire logic upper_run_bit,
   input wire logic lower_cmp_wr,
   input wire logic upper_cmp_wr,
   input wire logic [7:0] cmp_wr_data,
   input wire logic ff_cmd_wr,
   input wire logic [1:0] ff_cmd,
   output logic shared_timer_output_pin,
   output logic lower_timer_interrupt,
   output logic upper_timer_interrupt,
   output logic [7:0] lower_counter,
   output logic [7:0] upper_counter,
   output logic compare_enabled
);
   import dtp_pkg::*;

   logic ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_level_reg;
   logic ext_level_next;
   logic ext_edge;
   logic [CNT_W-1:0] lower_cmp_reg, lower_cmp_next;
   logic [CNT_W-1:0] lower_buf_reg, lower_buf_next;
   logic [CNT_W-1:0] upper_cmp_reg, upper_cmp_next;
   logic cmp_en_reg, cmp_en_next;
   logic ff_reg, ff_next;
   logic lower_int_reg, lower_int_next;
   logic upper_int_reg, upper_int_next;
   logic [CNT_W:0] lower_plus, upper_plus, pwm_limit;
   logic lower_tick, upper_tick, lower_run, upper_run;
   logic lower_clear, upper_clear;
   logic l_hit_cmp, l_hit_ucmp, l_wrap, pwm_ovf, u_hit, dbl_hit;
   logic toggle, reload;
   logic is_dual, is_16, is_ppg, is_pwm;

   assign is_dual = (cfg.mode == MODE_DUAL);
   assign is_16 = (cfg.mode == MODE_16BIT);
   assign is_ppg = (cfg.mode == MODE_PPG);
   assign is_pwm = (cfg.mode == MODE_PWM);

   // External clock: only the second stage reads the first
   assign ext_edge = (ext_s2_reg == ext_s3_reg) && ext_s2_reg && !ext_level_reg;
   assign ext_level_next = (ext_s2_reg == ext_s3_reg) ? ext_s2_reg : ext_level_reg;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
         ext_level_reg <= 1'b0;
      end
      else
      begin
         ext_s1_reg <= lower_ext_clk_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
         ext_level_reg <= ext_level_next;
      end
   end

   // PPG borrows the upper run bit as an enable of the pulse generator
   assign lower_run = lower_run_bit && (!is_ppg || upper_run_bit);
   assign upper_run = upper_run_bit && !is_ppg;

   always_comb
   begin
      lower_tick = 1'b0;
      case (cfg.lower_clk_sel)
         LCLK_EXT: lower_tick = ext_edge;
         LCLK_T1: lower_tick = taps.t1;
         LCLK_T4: lower_tick = taps.t4;
         LCLK_T16: lower_tick = taps.t16;
         default: lower_tick = 1'b0;
      endcase
      lower_tick = lower_tick && lower_run;
   end

   always_comb
   begin
      pwm_limit = PWM_LIM_256;
      case (cfg.pwm_cycle)
         PWM_CYC_64: pwm_limit = PWM_LIM_64;
         PWM_CYC_128: pwm_limit = PWM_LIM_128;
         PWM_CYC_256: pwm_limit = PWM_LIM_256;
         default: pwm_limit = PWM_LIM_256;
      endcase
   end

   // Comparisons use the value the counter is about to take
   assign l_hit_cmp = lower_tick && (lower_plus[CNT_W-1:0] == lower_cmp_reg);
   assign l_hit_ucmp = lower_tick && (lower_plus[CNT_W-1:0] == upper_cmp_reg);
   assign l_wrap = lower_tick && lower_plus[CNT_W];
   assign pwm_ovf = is_pwm && lower_tick && (lower_plus == pwm_limit);
   assign u_hit = upper_tick && (upper_plus[CNT_W-1:0] == upper_cmp_reg);
   // Joint match: lower match while the upper count already equals its compare
   assign dbl_hit = is_16 && cmp_en_reg && l_hit_cmp
                    && (upper_counter == upper_cmp_reg);

   always_comb
   begin
      upper_tick = 1'b0;
      if (is_16)
      begin
         upper_tick = l_wrap;
      end
      else if (!is_ppg)
      begin
         case (cfg.upper_clk_sel)
            UCLK_MATCH: upper_tick = l_hit_cmp;
            UCLK_T1: upper_tick = taps.t1;
            UCLK_T16: upper_tick = taps.t16;
            UCLK_T256: upper_tick = taps.t256;
            default: upper_tick = 1'b0;
         endcase
      end
      upper_tick = upper_tick && upper_run;
   end

   always_comb
   begin
      lower_clear = 1'b0;
      upper_clear = 1'b0;
      toggle = 1'b0;
      lower_int_next = 1'b0;
      upper_int_next = 1'b0;
      reload = 1'b0;
      case (cfg.mode)
         MODE_DUAL:
         begin
            lower_clear = l_hit_cmp;
            upper_clear = u_hit;
            toggle = cfg.out_select ? u_hit : l_hit_cmp;
            lower_int_next = l_hit_cmp;
            upper_int_next = u_hit;
         end
         MODE_16BIT:
         begin
            lower_clear = dbl_hit;
            upper_clear = dbl_hit;
            toggle = dbl_hit;
            upper_int_next = dbl_hit;
         end
         MODE_PPG:
         begin
            lower_clear = l_hit_ucmp;
            toggle = l_hit_cmp || l_hit_ucmp;
            lower_int_next = l_hit_ucmp;
            reload = cfg.dbuf_en && l_hit_ucmp;
         end
         MODE_PWM:
         begin
            lower_clear = pwm_ovf;
            toggle = l_hit_cmp || pwm_ovf;
            lower_int_next = pwm_ovf;
            upper_clear = u_hit;
            upper_int_next = u_hit;
            reload = cfg.dbuf_en && pwm_ovf;
         end
         default: lower_clear = 1'b0;
      endcase
   end

   dtp_counter #(
      .WIDTH(CNT_W)
   ) u_lower (
      .ref_clk(ref_clk),
      .reset(reset),
      .run(lower_run),
      .tick(lower_tick),
      .clear(lower_clear),
      .count(lower_counter),
      .count_plus(lower_plus)
   );

   dtp_counter #(
      .WIDTH(CNT_W)
   ) u_upper (
      .ref_clk(ref_clk),
      .reset(reset),
      .run(upper_run),
      .tick(upper_tick),
      .clear(upper_clear),
      .count(upper_counter),
      .count_plus(upper_plus)
   );

   // Compare registers; a same-cycle reload still loads the old buffer value while the write goes into the buffer
   always_comb
   begin
      lower_cmp_next = lower_cmp_reg;
      lower_buf_next = lower_buf_reg;
      upper_cmp_next = upper_cmp_reg;
      cmp_en_next = cmp_en_reg;
      if (reload)
         lower_cmp_next = lower_buf_reg;
      if (lower_cmp_wr)
      begin
         lower_buf_next = cmp_wr_data;
         if (!cfg.dbuf_en)
            lower_cmp_next = cmp_wr_data;
         cmp_en_next = 1'b0;
      end
      if (upper_cmp_wr)
      begin
         upper_cmp_next = cmp_wr_data;
         cmp_en_next = 1'b1;
      end
   end

   // Output flip-flop: software command first, so a preset polarity is exact
   always_comb
   begin
      ff_next = ff_reg;
      if (ff_cmd_wr && ff_cmd != FF_CMD_HOLD)
      begin
         case (ff_cmd)
            FF_CMD_INVERT: ff_next = !ff_reg;
            FF_CMD_CLEAR: ff_next = 1'b0;
            FF_CMD_SET: ff_next = 1'b1;
            default: ff_next = ff_reg;
         endcase
      end
      else if (toggle && cfg.invert_en)
      begin
         ff_next = !ff_reg;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         lower_cmp_reg <= CMP_RESET;
         lower_buf_reg <= CMP_RESET;
         upper_cmp_reg <= CMP_RESET;
         cmp_en_reg <= CMP_EN_RESET;
         ff_reg <= FF_RESET;
         lower_int_reg <= 1'b0;
         upper_int_reg <= 1'b0;
      end
      else
      begin
         lower_cmp_reg <= lower_cmp_next;
         lower_buf_reg <= lower_buf_next;
         upper_cmp_reg <= upper_cmp_next;
         cmp_en_reg <= cmp_en_next;
         ff_reg <= ff_next;
         lower_int_reg <= lower_int_next;
         upper_int_reg <= upper_int_next;
      end
   end

   assign shared_timer_output_pin = ff_reg;
   assign lower_timer_interrupt = lower_int_reg;
   assign upper_timer_interrupt = upper_int_reg;
   assign compare_enabled = cmp_en_reg;

   cascade_count_a: assert property (@(posedge ref_clk) disable iff (reset)
      is_dual && cfg.upper_clk_sel == UCLK_MATCH && upper_run && l_hit_cmp && !u_hit
      |=> upper_counter == $past(upper_plus[CNT_W-1:0]))
      else $error("upper timer missed a lower match pulse");

   ovf_feeds_upper_a: assert property (@(posedge ref_clk) disable iff (reset)
      is_16 && upper_run && l_wrap && !dbl_hit
      |=> upper_counter == $past(upper_plus[CNT_W-1:0]))
      else $error("lower overflow did not advance upper counter");

   cmp_suspend_a: assert property (@(posedge ref_clk) disable iff (reset)
      lower_cmp_wr && !upper_cmp_wr |=> !compare_enabled)
      else $error("compare not suspended after lower write");

   // Back-to-back lower then upper writes are legal, so only an upper write may resume
   cmp_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      !compare_enabled && !upper_cmp_wr |=> !compare_enabled)
      else $error("compare resumed without upper write");

   no_low_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      is_16 && l_hit_cmp && !dbl_hit |=> lower_counter == $past(lower_plus[CNT_W-1:0]))
      else $error("lower counter cleared by lone match");

   joint_match_a: assert property (@(posedge ref_clk) disable iff (reset)
      dbl_hit |=> lower_counter == CNT_RESET && upper_counter == CNT_RESET
      && upper_timer_interrupt)
      else $error("joint match did not clear both counters");

   ppg_toggle_a: assert property (@(posedge ref_clk) disable iff (reset)
      is_ppg && cfg.invert_en && (l_hit_cmp || l_hit_ucmp) && !ff_cmd_wr
      |=> shared_timer_output_pin != $past(shared_timer_output_pin))
      else $error("PPG output did not toggle on match");

   ppg_reload_a: assert property (@(posedge ref_clk) disable iff (reset)
      is_ppg && cfg.dbuf_en && l_hit_ucmp && !lower_cmp_wr
      |=> lower_cmp_reg == $past(lower_buf_reg) && lower_counter == CNT_RESET)
      else $error("PPG cycle end did not reload and clear");

   pwm_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      pwm_ovf |=> lower_counter == CNT_RESET && lower_timer_interrupt)
      else $error("PWM overflow did not clear lower counter");

   pwm_reload_a: assert property (@(posedge ref_clk) disable iff (reset)
      pwm_ovf && cfg.dbuf_en && !lower_cmp_wr |=> lower_cmp_reg == $past(lower_buf_reg))
      else $error("PWM overflow did not reload compare");
endmodule // dtp_timer_pair
`default_nettype wire

// ==== testbench/dtp_timer_pair_tb.sv ====
/*
 Self-checking bench for the paired 8-bit timer block in all four modes.
 Assumes dtp_pkg and the timer block are compiled first; taps come from a bench divider.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_timer_pair_tb;
   import dtp_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   dtp_cfg_t cfg = '0;
   dtp_taps_t taps = '0;
   logic lower_run_bit = 1'b0;
   logic upper_run_bit = 1'b0;
   logic lower_cmp_wr = 1'b0;
   logic upper_cmp_wr = 1'b0;
   logic [7:0] cmp_wr_data = 8'h00;
   logic ff_cmd_wr = 1'b0;
   logic [1:0] ff_cmd = 2'b11;
   logic pin;
   logic lower_int;
   logic upper_int;
   logic [7:0] lower_counter;
   logic [7:0] upper_counter;
   logic compare_enabled;
   logic ext_pin = 1'b0;
   logic [7:0] div = 8'h00;
   logic [15:0] n;
   int failures = 0;
   int checks = 0;

   dtp_timer_pair u_dtp_timer_pair (
      .ref_clk(ref_clk),
      .reset(reset),
      .cfg(cfg),
      .taps(taps),
      .lower_ext_clk_pin(ext_pin),
      .lower_run_bit(lower_run_bit),
      .upper_run_bit(upper_run_bit),
      .lower_cmp_wr(lower_cmp_wr),
      .upper_cmp_wr(upper_cmp_wr),
      .cmp_wr_data(cmp_wr_data),
      .ff_cmd_wr(ff_cmd_wr),
      .ff_cmd(ff_cmd),
      .shared_timer_output_pin(pin),
      .lower_timer_interrupt(lower_int),
      .upper_timer_interrupt(upper_int),
      .lower_counter(lower_counter),
      .upper_counter(upper_counter),
      .compare_enabled(compare_enabled)
   );

   always #10 ref_clk = ~ref_clk;

   // Free-running divider stands in for the prescaler
   always @(posedge ref_clk)
   begin
      #1;
      div = div + 8'h01;
      taps = '{t1: 1'b1, t4: div[1:0] == 2'b00, t16: div[3:0] == 4'h0, t256: div == 8'h00};
   end

   function automatic logic sig(input int i);
      case (i)
         0: return lower_int;
         1: return upper_int;
         default: return pin;
      endcase
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Rise to rise, or rise to fall when hi is set; sampled mid-cycle to dodge edge races
   task automatic meas(input int i, input logic hi, output logic [15:0] len);
      logic p;
      logic [15:0] k;
      k = 16'h0000;
      do
      begin
         p = sig(i);
         @(negedge ref_clk);
         k++;
      end
      while (!(p === 1'b0 && sig(i) === 1'b1) && k < 16'h0bb8);
      len = 16'h0000;
      do
      begin
         p = sig(i);
         @(negedge ref_clk);
         len++;
      end
      while (!(p === 1'b0 && sig(i) === 1'b1) && !(hi && p === 1'b1 && sig(i) === 1'b0)
             && len < 16'h0bb8);
   endtask

   // Kind 0 lower compare, 1 upper compare, 2 flip-flop command
   task automatic pulse(input int k, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      cmp_wr_data = d;
      ff_cmd = d[1:0];
      lower_cmp_wr = (k == 0);
      upper_cmp_wr = (k == 1);
      ff_cmd_wr = (k == 2);
      @(posedge ref_clk);
      #1;
      lower_cmp_wr = 1'b0;
      upper_cmp_wr = 1'b0;
      ff_cmd_wr = 1'b0;
   endtask

   // Stopping both runs clears the counters, so each phase starts aligned
   task automatic run(input logic lo, input logic up);
      @(posedge ref_clk);
      #1;
      lower_run_bit = lo;
      upper_run_bit = up;
   endtask

   task automatic test_dual();
      chk(lower_counter, 16'h0000);
      chk(pin, 16'h0000);
      chk(compare_enabled, 16'h0001);
      run(1'b0, 1'b0);
      cfg = '{mode: MODE_DUAL, pwm_cycle: 2'b00, upper_clk_sel: UCLK_MATCH,
              lower_clk_sel: LCLK_T1, dbuf_en: 1'b0, invert_en: 1'b1, out_select: 1'b0};
      pulse(0, 8'h05);
      pulse(1, 8'h03);
      pulse(2, {6'h00, FF_CMD_CLEAR});
      run(1'b1, 1'b1);
      meas(0, 1'b0, n);
      chk(n, 16'h0005);
      meas(1, 1'b0, n);
      chk(n, 16'h000f);
      meas(2, 1'b1, n);
      chk(n, 16'h0005);
      run(1'b1, 1'b1);
      cfg.out_select = 1'b1;
      meas(2, 1'b1, n);
      chk(n, 16'h000f);
      $display("test dual done");
   endtask

   task automatic test_wide();
      logic [15:0] c;
      logic [7:0] mx;
      run(1'b0, 1'b0);
      cfg.mode = MODE_16BIT;
      cfg.upper_clk_sel = UCLK_T256;
      pulse(0, 8'h04);
      chk(compare_enabled, 16'h0000);
      run(1'b1, 1'b1);
      c = 16'h0000;
      repeat (600)
      begin
         @(negedge ref_clk);
         if (upper_int === 1'b1)
            c++;
      end
      chk(c, 16'h0000);
      chk(upper_counter, 16'h0002);
      run(1'b0, 1'b0);
      pulse(1, 8'h01);
      chk(compare_enabled, 16'h0001);
      run(1'b1, 1'b1);
      meas(1, 1'b0, n);
      chk(n, 16'h0104);
      meas(2, 1'b1, n);
      chk(n, 16'h0104);
      mx = 8'h00;
      repeat (300)
      begin
         @(negedge ref_clk);
         if (lower_counter > mx)
            mx = lower_counter;
      end
      chk(mx, 16'h00ff);
      $display("test wide done");
   endtask

   task automatic test_ppg();
      run(1'b0, 1'b0);
      cfg.mode = MODE_PPG;
      pulse(0, 8'h03);
      pulse(1, 8'h08);
      pulse(2, {6'h00, FF_CMD_CLEAR});
      run(1'b1, 1'b1);
      meas(0, 1'b0, n);
      chk(n, 16'h0008);
      meas(2, 1'b1, n);
      chk(n, 16'h0005);
      run(1'b0, 1'b0);
      pulse(2, {6'h00, FF_CMD_SET});
      run(1'b1, 1'b1);
      meas(2, 1'b1, n);
      chk(n, 16'h0003);
      chk(upper_counter, 16'h0000);
      run(1'b1, 1'b1);
      cfg.dbuf_en = 1'b1;
      pulse(0, 8'h06);
      meas(2, 1'b1, n);
      meas(2, 1'b1, n);
      chk(n, 16'h0006);
      $display("test ppg done");
   endtask

   task automatic test_pwm();
      logic [15:0] lim;
      for (int k = 1; k < 4; k++)
      begin
         lim = 16'h0020 << k;
         run(1'b0, 1'b0);
         cfg.mode = MODE_PWM;
         cfg.pwm_cycle = k[1:0];
         cfg.dbuf_en = 1'b0;
         cfg.upper_clk_sel = UCLK_T1;
         pulse(0, 8'h20);
         pulse(1, 8'h05);
         pulse(2, {6'h00, FF_CMD_CLEAR});
         run(1'b1, 1'b1);
         meas(0, 1'b0, n);
         chk(n, lim);
         meas(2, 1'b1, n);
         chk(n, lim - 16'h0020);
         meas(1, 1'b0, n);
         chk(n, 16'h0005);
         run(1'b1, 1'b1);
         cfg.dbuf_en = 1'b1;
         pulse(0, 8'h30);
         meas(2, 1'b1, n);
         meas(2, 1'b1, n);
         chk(n, lim - 16'h0030);
      end
      run(1'b1, 1'b1);
      cfg.pwm_cycle = PWM_CYC_64;
      cfg.lower_clk_sel = LCLK_T4;
      meas(0, 1'b0, n);
      meas(0, 1'b0, n);
      chk(n, 16'h0100);
      $display("test pwm done");
   endtask

   // External clock pin: three slow rising edges, then a software invert of the output
   task automatic test_ext();
      logic p;
      run(1'b0, 1'b0);
      cfg.mode = MODE_DUAL;
      cfg.lower_clk_sel = LCLK_EXT;
      cfg.dbuf_en = 1'b0;
      run(1'b1, 1'b0);
      repeat (6)
      begin
         repeat (4) @(posedge ref_clk);
         #1;
         ext_pin = ~ext_pin;
      end
      repeat (6) @(posedge ref_clk);
      #1;
      chk(lower_counter, 16'h0003);
      p = pin;
      pulse(2, {6'h00, FF_CMD_INVERT});
      chk(pin, {15'h0000, ~p});
      $display("test ext done");
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Whole run is well under 20k cycles; a hang is cut at 100k
   initial
   begin
      #2000000;
      failures++;
      test_done();
   end

   initial
   begin
      repeat (4) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      test_dual();
      test_wide();
      test_ppg();
      test_pwm();
      test_ext();
      test_done();
   end
endmodule // dtp_timer_pair_tb
`default_nettype wire
